// ===== hw/incremental_adc_sequencer.sv
/*
  incremental sigma-delta adc sequencer with an avalon-mm register slave.
  assumes a synchronous modulator bit on mod_bit_in, valid at each
  sample strobe, and mclk_in as the extended rc frequency.
*/
// The register offsets and register access over Avalon-MM are this design's own decisions.
// Behaviour
// RQ1: start or alternate trigger bit begins conversion
// RQ2: n elementary conversions then one quantization step
// RQ3: elementary conversion lasts osr plus one periods
// RQ4: result is mean of elementary results
// RQ5: offset polarity alternates between elementary conversions
// RQ6: extra clock cycles at start and end
// RQ7: rate field selects divide by 8/16/64/slow
// RQ8: osr equals two to three plus field
// RQ9: elementary count equals two to field
// RQ10: software picks count of two for offset
// RQ11: resolution two log2 osr plus log2 count
// RQ12: larger osr and count allowed, advisory
// RQ13: total time n times osr+1 plus one
// RQ14: result is 16-bit two's complement
// RQ15: out of range saturates to full scale
// RQ16: low non-significant bits forced below 16 bits
// RQ17: forced pattern is one followed by zeros
// RQ18: four enable bits for adc and stages
// RQ19: result held until done, then flagged
`timescale 1ns/10ps
module incremental_adc_sequencer
  import adc_seq_pkg::*;
#(
  parameter int SLOW_DIV = SLOW_DIV_CYC,
  parameter int ACC_W = 28
) (
  input wire logic mclk_in,
  input wire logic srst_in,
  input wire logic [3:0] address_in,
  input wire logic read_in,
  input wire logic write_in,
  input wire logic [31:0] writedata_in,
  input wire logic [3:0] byteenable_in,
  output logic [31:0] readdata_out,
  output logic waitrequest_out,
  input wire logic mod_bit_in,
  output logic [3:0] enable_out,
  output logic sample_strobe_out,
  output logic offset_polarity_out,
  output logic modulator_reset_out,
  output logic busy_out
);

  ////////////////////////////////////////////////////////////////////////
  // functions
  // RQ8: osr from field
  function automatic logic [10:0] osr_of(input logic [2:0] s);
    osr_of = 11'h008 << s;
  endfunction

  function automatic logic [3:0] nelc_of(input logic [1:0] s);
    nelc_of = 4'h1 << s;
  endfunction

  function automatic logic [13:0] div_of(input logic [1:0] r);
    case (r)
      2'b00: div_of = DIV_RATE0;
      2'b01: div_of = DIV_RATE1;
      2'b10: div_of = DIV_RATE2;
      default: div_of = 14'(SLOW_DIV);
    endcase
  endfunction

  // mean, scaling to 16 bits, saturation and forced low bits
  function automatic logic [15:0] scale_result(
    input logic signed [ACC_W-1:0] s,
    input logic [2:0] o,
    input logic [1:0] n
  );
    logic signed [47:0] w;
    int sh;
    logic [15:0] r;
    // RQ11: resolution sets the shift
    sh = RES_W - 2 * (OSR_BASE_LOG2 + int'(o)) - int'(n);
    w = 48'(s);
    if (sh >= 0) begin
      w = w <<< sh;
    end else begin
      w = w >>> (-sh);
    end
    if (w > 48'sh0000_7fff) begin
      r = SAT_POS;
    end else if (w < -48'sh0000_8000) begin
      r = SAT_NEG;
    end else begin
      // RQ14: two's complement word
      r = w[15:0];
      if (sh > 0) begin
        // RQ17: one then zeros below
        r = (r & ~((16'h0001 << sh) - 16'h0001)) | (16'h0001 << (sh - 1));
      end
    end
    scale_result = r;
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // declarations
  acq_cfg_s cfg_ff, nxt_cfg, run_ff, nxt_run;
  logic wait_ff, nxt_wait;
  logic [31:0] rdata_ff, nxt_rdata;
  logic done_ff, nxt_done;
  logic busy_ff;
  logic trig, seq_done, tick;
  seq_state_e state_ff, nxt_state;
  logic [13:0] div_ff, nxt_div;
  logic [10:0] samp_ff, nxt_samp;
  logic [3:0] elem_ff, nxt_elem;
  logic pol_ff, nxt_pol;
  logic signed [11:0] acc1_ff, nxt_acc1;
  logic signed [ACC_W-1:0] acc2_ff, nxt_acc2, sum_ff, nxt_sum, a2, ev;
  logic [15:0] result_ff, nxt_result;
  logic strobe_ff, nxt_strobe, modrst_ff, nxt_modrst;

  ////////////////////////////////////////////////////////////////////////
  // bus slave, configuration and status
  always_comb begin
    nxt_wait = 1'b1;
    nxt_rdata = rdata_ff;
    nxt_cfg = cfg_ff;
    nxt_done = done_ff;
    trig = 1'b0;
    // one wait state, read data captured while waitrequest is high
    if ((read_in || write_in) && wait_ff) begin
      nxt_wait = 1'b0;
      case (address_in)
        ADDR_CFG0: nxt_rdata = {24'h00_0000, 1'b0, cfg_ff.nelc,
                                cfg_ff.osr, 2'b00};
        ADDR_CFG1: nxt_rdata = {24'h00_0000, cfg_ff.enable, 2'b00,
                                cfg_ff.rate};
        ADDR_RESULT: nxt_rdata = {16'h0000, result_ff};
        ADDR_STATUS: nxt_rdata = {30'h0000_0000, done_ff, busy_ff};
        default: nxt_rdata = 32'h0000_0000;
      endcase
    end
    // writes land only at the edge that completes the transfer
    if (write_in && !wait_ff && byteenable_in[0]) begin
      case (address_in)
        ADDR_CFG0: begin
          nxt_cfg.osr = writedata_in[CFG0_OSR_LSB +: 3];
          nxt_cfg.nelc = writedata_in[CFG0_NELC_LSB +: 2];
          // RQ1: either trigger starts
          trig = writedata_in[CFG0_START_BIT] | writedata_in[CFG0_ALT_BIT];
        end
        ADDR_CFG1: begin
          nxt_cfg.rate = writedata_in[CFG1_RATE_LSB +: 2];
          // RQ18: stage enable word
          nxt_cfg.enable = writedata_in[CFG1_EN_LSB +: 4];
        end
        ADDR_STATUS: begin
          if (writedata_in[STAT_DONE_BIT]) begin
            nxt_done = 1'b0;
          end
        end
        default: begin
        end
      endcase
    end
    // RQ19: done set beats clear
    if (seq_done) begin
      nxt_done = 1'b1;
    end
  end

  always_ff @(posedge mclk_in) begin
    if (srst_in) begin
      wait_ff <= 1'b1;
      rdata_ff <= 32'h0000_0000;
      cfg_ff <= '{enable: EN_RST, rate: RATE_RST, nelc: NELC_RST,
                  osr: OSR_RST};
      done_ff <= 1'b0;
    end else begin
      wait_ff <= nxt_wait;
      rdata_ff <= nxt_rdata;
      cfg_ff <= nxt_cfg;
      done_ff <= nxt_done;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // conversion sequencer; rate, count and oversampling settings are latched at start so that
  // software may reprogram the next conversion without upsetting this one; enable_out follows cfg_ff at once
  always_comb begin
    nxt_state = state_ff;
    nxt_run = run_ff;
    nxt_div = div_ff;
    nxt_samp = samp_ff;
    nxt_elem = elem_ff;
    nxt_pol = pol_ff;
    nxt_acc1 = acc1_ff;
    nxt_acc2 = acc2_ff;
    nxt_sum = sum_ff;
    nxt_result = result_ff;
    nxt_strobe = 1'b0;
    nxt_modrst = 1'b0;
    seq_done = 1'b0;
    a2 = acc2_ff;
    ev = '0;
    tick = (div_ff == 14'h0000);
    case (state_ff)
      ST_IDLE: begin
      end
      ST_INIT: begin
        // RQ6: setup cycles before sampling
        if (tick) begin
          nxt_state = ST_RUN;
          // RQ7: sample period divider
          nxt_div = div_of(run_ff.rate) - 14'h0001;
          nxt_modrst = 1'b1;
        end else begin
          nxt_div = div_ff - 14'h0001;
        end
      end
      ST_RUN: begin
        if (tick) begin
          nxt_div = div_of(run_ff.rate) - 14'h0001;
          nxt_strobe = 1'b1;
          // second order incremental filter
          nxt_acc1 = acc1_ff + (mod_bit_in ? 12'sh001 : 12'shfff);
          a2 = acc2_ff + ACC_W'(nxt_acc1);
          nxt_acc2 = a2;
          nxt_samp = samp_ff + 11'h001;
          // RQ3: osr plus one samples
          if (samp_ff == osr_of(run_ff.osr)) begin
            // RQ5: undo the chopped sign
            ev = pol_ff ? -a2 : a2;
            // RQ4: accumulate for the mean
            nxt_sum = sum_ff + ev;
            nxt_pol = ~pol_ff;
            nxt_elem = elem_ff + 4'h1;
            nxt_acc1 = '0;
            nxt_acc2 = '0;
            nxt_samp = 11'h000;
            nxt_modrst = 1'b1;
            // RQ9: elementary count reached
            if (elem_ff == nelc_of(run_ff.nelc) - 4'h1) begin
              nxt_state = ST_QUANT;
            end
          end
        end else begin
          nxt_div = div_ff - 14'h0001;
        end
      end
      ST_QUANT: begin
        // RQ2: final quantization period
        if (tick) begin
          nxt_strobe = 1'b1;
          nxt_state = ST_FINISH;
          nxt_div = FINISH_CYC - 14'h0001;
        end else begin
          nxt_div = div_ff - 14'h0001;
        end
      end
      ST_FINISH: begin
        if (tick) begin
          // RQ15: saturated, RQ16: forced low bits
          nxt_result = scale_result(sum_ff, run_ff.osr, run_ff.nelc);
          seq_done = 1'b1;
          nxt_state = ST_IDLE;
        end else begin
          nxt_div = div_ff - 14'h0001;
        end
      end
      default: begin
        nxt_state = ST_IDLE;
      end
    endcase
    // RQ1: a trigger restarts from any state
    if (trig) begin
      nxt_state = ST_INIT;
      nxt_run = nxt_cfg;
      nxt_div = INIT_CYC - 14'h0001;
      nxt_samp = 11'h000;
      nxt_elem = 4'h0;
      nxt_pol = 1'b0;
      nxt_acc1 = '0;
      nxt_acc2 = '0;
      nxt_sum = '0;
      seq_done = 1'b0;
      // no stale pulse from the aborted run
      nxt_strobe = 1'b0;
      nxt_modrst = 1'b0;
      nxt_result = result_ff;
    end
  end

  always_ff @(posedge mclk_in) begin
    if (srst_in) begin
      state_ff <= ST_IDLE;
      run_ff <= '{enable: EN_RST, rate: RATE_RST, nelc: NELC_RST,
                  osr: OSR_RST};
      div_ff <= 14'h0000;
      samp_ff <= 11'h000;
      elem_ff <= 4'h0;
      pol_ff <= 1'b0;
      acc1_ff <= '0;
      acc2_ff <= '0;
      sum_ff <= '0;
      result_ff <= RESULT_RST;
      strobe_ff <= 1'b0;
      modrst_ff <= 1'b0;
      busy_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      run_ff <= nxt_run;
      div_ff <= nxt_div;
      samp_ff <= nxt_samp;
      elem_ff <= nxt_elem;
      pol_ff <= nxt_pol;
      acc1_ff <= nxt_acc1;
      acc2_ff <= nxt_acc2;
      sum_ff <= nxt_sum;
      result_ff <= nxt_result;
      strobe_ff <= nxt_strobe;
      modrst_ff <= nxt_modrst;
      busy_ff <= (nxt_state != ST_IDLE);
    end
  end

  // outputs all come from flip-flops
  assign readdata_out = rdata_ff;
  assign waitrequest_out = wait_ff;
  assign enable_out = cfg_ff.enable;
  assign sample_strobe_out = strobe_ff;
  assign offset_polarity_out = pol_ff;
  assign modulator_reset_out = modrst_ff;
  assign busy_out = busy_ff;

  ////////////////////////////////////////////////////////////////////////
  // checking helpers: sample ticks per conversion and forced bit count
  logic [14:0] tick_tot_ff;
  logic [14:0] tot_exp;
  logic [4:0] res_bits, force_n;
  // RQ13: sample ticks per run
  always_ff @(posedge mclk_in) begin
    if (srst_in || trig) begin
      tick_tot_ff <= 15'h0000;
    end else if (tick && (state_ff == ST_RUN || state_ff == ST_QUANT)) begin
      tick_tot_ff <= tick_tot_ff + 15'h0001;
    end
  end
  assign tot_exp = 15'(nelc_of(run_ff.nelc)) *
                   (15'(osr_of(run_ff.osr)) + 15'h0001) + 15'h0001;
  assign res_bits = 5'h06 + {1'b0, run_ff.osr, 1'b0} + {3'h0, run_ff.nelc};
  assign force_n = (res_bits < 5'h10) ? 5'h10 - res_bits : 5'h00;

  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (srst_in);

  property p_trig_start;
    trig |=> state_ff == ST_INIT && busy_out;
  endproperty
  a_trig_start: assert property (p_trig_start) // RQ1
    else $error("trigger did not start a conversion");

  property p_total_time;
    (state_ff == ST_QUANT && tick && !trig) |=> tick_tot_ff == tot_exp;
  endproperty
  a_total_time: assert property (p_total_time) // RQ13
    else $error("conversion sample count wrong");

  property p_elem_len;
    (state_ff == ST_RUN && tick && !trig &&
     samp_ff == (11'h008 << run_ff.osr)) |=> samp_ff == 11'h000 && modrst_ff;
  endproperty
  a_elem_len: assert property (p_elem_len) // RQ3
    else $error("elementary conversion length wrong");

  property p_pol_alt;
    (state_ff == ST_RUN && modrst_ff && $past(state_ff) == ST_RUN)
      |-> pol_ff != $past(pol_ff);
  endproperty
  a_pol_alt: assert property (p_pol_alt) // RQ5
    else $error("offset polarity did not alternate");

  property p_init_len;
    @(posedge mclk_in) disable iff (srst_in || trig)
    $rose(state_ff == ST_INIT) |-> (state_ff == ST_INIT)[*2]
      ##1 state_ff == ST_RUN;
  endproperty
  a_init_len: assert property (p_init_len) // RQ6
    else $error("setup cycles wrong");

  property p_rate0;
    (state_ff == ST_RUN && tick && run_ff.rate == 2'b00 && !trig)
      |=> (!strobe_ff || $past(tick)) ##1 !sample_strobe_out[*7]
      ##1 (sample_strobe_out || state_ff != ST_RUN);
  endproperty
  a_rate0: assert property (p_rate0) // RQ7
    else $error("sample period not eight clocks");

  property p_nelc;
    (state_ff == ST_RUN && nxt_state == ST_QUANT && !trig)
      |=> elem_ff == (4'h1 << run_ff.nelc);
  endproperty
  a_nelc: assert property (p_nelc) // RQ9
    else $error("elementary count wrong");

  property p_forced;
    seq_done |=> (force_n == 5'h00 || result_ff == SAT_POS ||
      result_ff == SAT_NEG || (result_ff &
      ((16'h0001 << force_n) - 16'h0001)) == (16'h0001 << (force_n - 5'h01)));
  endproperty
  a_forced: assert property (p_forced) // RQ16
    else $error("forced low bits wrong");

  property p_hold;
    !$past(seq_done) |-> $stable(result_ff);
  endproperty
  a_hold: assert property (p_hold) // RQ19
    else $error("result changed outside completion");

  property p_done_flag;
    seq_done |=> done_ff && !busy_out;
  endproperty
  a_done_flag: assert property (p_done_flag) // RQ19
    else $error("completion not flagged");

  c_full_seq: cover property (seq_done && run_ff.nelc == 2'b11);
  c_restart: cover property (state_ff == ST_RUN && trig);
  c_slow: cover property (state_ff == ST_RUN && run_ff.rate == 2'b11 && tick);
  c_sat: cover property (seq_done ##1 result_ff == SAT_POS);

endmodule

// ===== hw/adc_seq_pkg.sv
/*
  shared constants, field layouts and types of the incremental adc
  sequencer: register offsets, field positions, reset values, timing.
  assumes the core clock doubles as the extended rc frequency.
*/
package adc_seq_pkg;

  ////////////////////////////////////////////////////////////////////////
  // clock and timing
  localparam int CLK_HZ = 40_000_000;
  localparam int SLOW_FS_HZ = 4000;
  localparam int SLOW_DIV_CYC = CLK_HZ / SLOW_FS_HZ;
  localparam logic [13:0] DIV_RATE0 = 14'h0008;
  localparam logic [13:0] DIV_RATE1 = 14'h0010;
  localparam logic [13:0] DIV_RATE2 = 14'h0040;
  localparam logic [13:0] INIT_CYC = 14'h0002;
  localparam logic [13:0] FINISH_CYC = 14'h0002;

  ////////////////////////////////////////////////////////////////////////
  // register byte offsets
  localparam logic [3:0] ADDR_CFG0 = 4'h0;
  localparam logic [3:0] ADDR_CFG1 = 4'h4;
  localparam logic [3:0] ADDR_RESULT = 4'h8;
  localparam logic [3:0] ADDR_STATUS = 4'hc;

  // field positions
  localparam int CFG0_START_BIT = 0;
  localparam int CFG0_OSR_LSB = 2;
  localparam int CFG0_NELC_LSB = 5;
  localparam int CFG0_ALT_BIT = 7;
  localparam int CFG1_RATE_LSB = 0;
  localparam int CFG1_EN_LSB = 4;
  localparam int STAT_BUSY_BIT = 0;
  localparam int STAT_DONE_BIT = 1;

  // reset values
  localparam logic [2:0] OSR_RST = 3'h0;
  localparam logic [1:0] NELC_RST = 2'h0;
  localparam logic [1:0] RATE_RST = 2'h0;
  localparam logic [3:0] EN_RST = 4'h0;
  localparam logic [15:0] RESULT_RST = 16'h0000;

  // result format
  localparam int OSR_BASE_LOG2 = 3;
  localparam int RES_W = 16;
  localparam logic [15:0] SAT_POS = 16'h7fff;
  localparam logic [15:0] SAT_NEG = 16'h8000;

  ////////////////////////////////////////////////////////////////////////
  // types
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_INIT = 3'b001,
    ST_RUN = 3'b010,
    ST_QUANT = 3'b011,
    ST_FINISH = 3'b100
  } seq_state_e;

  typedef struct packed {
    logic [3:0] enable;
    logic [1:0] rate;
    logic [1:0] nelc;
    logic [2:0] osr;
  } acq_cfg_s;

endpackage

// ===== sim/testbench.sv
/*
  self-checking bench of the incremental adc sequencer: avalon tasks,
  conversion runs per rate, count and oversampling field, saturation,
  forced low bits, retrigger and done flag.
  assumes the design package and a short slow divider.
*/
`timescale 1ns/10ps
module testbench;
  import adc_seq_pkg::*;
  localparam int SDIV = 20;
  logic mclk_in = 1'b0;
  logic srst_in = 1'b1;
  logic [3:0] address_in = 4'h0;
  logic read_in = 1'b0;
  logic write_in = 1'b0;
  logic [31:0] writedata_in = 32'h0000_0000;
  logic [3:0] byteenable_in = 4'hf;
  logic mod_bit_in = 1'b0;
  logic [31:0] readdata_out;
  logic waitrequest_out, sample_strobe_out, offset_polarity_out;
  logic modulator_reset_out, busy_out;
  logic [3:0] enable_out;
  logic [31:0] rd, prev;
  int failures = 0;
  int checked = 0;
  int strobes, resets, toggles, busy_cyc, gap, last_gap, mode;
  logic prev_pol = 1'b0;

  incremental_adc_sequencer #(.SLOW_DIV(SDIV)) i_dut (
    .mclk_in(mclk_in), .srst_in(srst_in), .address_in(address_in),
    .read_in(read_in), .write_in(write_in), .writedata_in(writedata_in),
    .byteenable_in(byteenable_in), .readdata_out(readdata_out),
    .waitrequest_out(waitrequest_out), .mod_bit_in(mod_bit_in),
    .enable_out(enable_out), .sample_strobe_out(sample_strobe_out),
    .offset_polarity_out(offset_polarity_out),
    .modulator_reset_out(modulator_reset_out), .busy_out(busy_out)
  );

  // 40 mhz clock
  always #12.5 mclk_in = ~mclk_in;

  ////////////////////////////////////////////////////////////////////////
  // modulator stimulus: constant high, constant low or toggling per tick
  always @(posedge mclk_in) begin
    if (mode == 2 && sample_strobe_out === 1'b1) begin
      mod_bit_in <= ~mod_bit_in;
    end else if (mode != 2) begin
      mod_bit_in <= (mode == 1);
    end
  end

  // counts strobes, restarts and polarity flips while busy
  always @(posedge mclk_in) begin
    if (busy_out === 1'b1) begin
      busy_cyc++;
      gap++;
      if (sample_strobe_out === 1'b1) begin
        strobes++;
        last_gap = gap;
        gap = 0;
      end
      if (modulator_reset_out === 1'b1) resets++;
      if (offset_polarity_out !== prev_pol) toggles++;
    end
    prev_pol = offset_polarity_out;
  end

  ////////////////////////////////////////////////////////////////////////
  task check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      failures++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // holds the request until waitrequest is sampled low
  task wait_ack;
    int n;
    n = 0;
    do begin
      @(posedge mclk_in);
      n++;
    end while (waitrequest_out !== 1'b0 && n < 100);
    if (n >= 100) check(32'h0000_0dea, 32'h0000_0000);
  endtask

  task bus_write(input logic [3:0] a, input logic [31:0] d,
                 input logic [3:0] be);
    @(posedge mclk_in);
    address_in <= a;
    writedata_in <= d;
    byteenable_in <= be;
    write_in <= 1'b1;
    wait_ack();
    write_in <= 1'b0;
  endtask

  task bus_read(input logic [3:0] a, output logic [31:0] d);
    @(posedge mclk_in);
    address_in <= a;
    read_in <= 1'b1;
    wait_ack();
    d = readdata_out;
    read_in <= 1'b0;
  endtask

  // one conversion, waited out only when wait_end is set; counters cleared just after the trigger
  task conv(input logic [1:0] rate, input logic [2:0] osr,
            input logic [1:0] nelc, input bit alt, input bit wait_end);
    int n;
    bus_write(ADDR_CFG1, {24'h0, 4'hf, 2'b00, rate}, 4'hf);
    bus_write(ADDR_CFG0, {24'h0, alt, nelc, osr, 1'b0, !alt}, 4'h1);
    // busy only shows one edge after the trigger lands, and a stale
    // strobe of an aborted run can no longer be sampled by then
    @(posedge mclk_in);
    strobes = 0;
    resets = 0;
    toggles = 0;
    busy_cyc = 0;
    gap = 0;
    n = 0;
    while (wait_end && busy_out !== 1'b0 && n < 20000) begin
      @(posedge mclk_in);
      n++;
    end
    if (n >= 20000) check(32'h0000_0bad, 32'h0000_0000);
    @(posedge mclk_in);
  endtask

  // strobe count, spacing, elementary restarts and low-bit pattern
  task conv_checks(input int d, input logic [2:0] osr, input logic [1:0] nelc);
    int t, k;
    t = (1 << nelc) * ((8 << osr) + 1) + 1;
    k = 16 - (2 * (3 + osr) + nelc);
    check(strobes, t);
    check(last_gap, d);
    check(resets, (1 << nelc) + 1);
    check(busy_cyc > t * d, 1);
    check(toggles >= (1 << nelc), 1);
    bus_read(ADDR_RESULT, rd);
    if (k > 0) check(rd & ((1 << k) - 1), 1 << (k - 1));
  endtask

  task finish_test;
    $display("comparisons %0d, mismatches %0d", checked, failures);
    if (failures == 0 && checked > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // watchdog well past the expected run length
  initial begin
    #(25 * 80000);
    failures++;
    finish_test();
  end

  ////////////////////////////////////////////////////////////////////////
  initial begin
    int dv[4];
    dv = '{8, 16, 64, SDIV};
    mode = 2;
    repeat (8) @(posedge mclk_in);
    srst_in <= 1'b0;
    // register values after reset
    bus_read(ADDR_CFG0, rd);
    check(rd, 32'h0000_0000);
    bus_read(ADDR_CFG1, rd);
    check(rd, 32'h0000_0000);
    bus_read(ADDR_RESULT, rd);
    check(rd, {16'h0, RESULT_RST});
    bus_read(ADDR_STATUS, rd);
    check(rd, 32'h0000_0000);
    $display("test reset done");
    // enable word, ignored lane, fields without trigger
    bus_write(ADDR_CFG1, 32'h0000_00a0, 4'hf);
    // the write lands at the completing edge; look one edge later
    @(posedge mclk_in);
    check(enable_out, 4'ha);
    bus_write(ADDR_CFG1, 32'h0000_0050, 4'he);
    @(posedge mclk_in);
    check(enable_out, 4'ha);
    bus_write(ADDR_CFG0, 32'h0000_007c, 4'hf);
    bus_read(ADDR_CFG0, rd);
    check(rd, 32'h0000_007c);
    check(busy_out, 1'b0);
    $display("test config done");
    // every sample rate, shortest sequence
    for (int r = 0; r < 4; r++) begin
      conv(r[1:0], 3'h0, 2'h0, 1'b0, 1'b1);
      conv_checks(dv[r], 3'h0, 2'h0);
    end
    $display("test rates done");
    // longer counts and oversampling, forced low bits
    conv(2'h0, 3'h0, 2'h3, 1'b0, 1'b1);
    conv_checks(8, 3'h0, 2'h3);
    conv(2'h0, 3'h3, 2'h3, 1'b1, 1'b1);
    conv_checks(8, 3'h3, 2'h3);
    conv(2'h0, 3'h4, 2'h1, 1'b0, 1'b1);
    conv_checks(8, 3'h4, 2'h1);
    // more resolution than the word holds, right shift path
    conv(2'h0, 3'h5, 2'h1, 1'b0, 1'b1);
    conv_checks(8, 3'h5, 2'h1);
    $display("test fields done");
    // full-scale inputs saturate
    mode = 1;
    conv(2'h0, 3'h1, 2'h0, 1'b0, 1'b1);
    bus_read(ADDR_RESULT, rd);
    check(rd, {16'h0, SAT_POS});
    mode = 0;
    conv(2'h0, 3'h1, 2'h0, 1'b1, 1'b1);
    bus_read(ADDR_RESULT, rd);
    check(rd, {16'h0, SAT_NEG});
    bus_read(ADDR_STATUS, rd);
    check(rd, 32'h0000_0002);
    bus_write(ADDR_STATUS, 32'h0000_0002, 4'hf);
    bus_read(ADDR_STATUS, rd);
    check(rd, 32'h0000_0000);
    $display("test saturation done");
    // retrigger mid-run keeps old result until the new one lands
    prev = rd;
    bus_read(ADDR_RESULT, prev);
    mode = 1;
    conv(2'h2, 3'h3, 2'h3, 1'b0, 1'b0);
    repeat (300) @(posedge mclk_in);
    bus_read(ADDR_RESULT, rd);
    check(rd, prev);
    bus_read(ADDR_STATUS, rd);
    check(rd, 32'h0000_0001);
    conv(2'h0, 3'h0, 2'h0, 1'b1, 1'b1);
    check(strobes, 10);
    bus_read(ADDR_RESULT, rd);
    check(rd, {16'h0, SAT_POS});
    $display("test retrigger done");
    finish_test();
  end
endmodule
